// file: design/idp_pkg.sv
// shared constants and types for the two-wire identification port
package idp_pkg;
  // ===========================================================
  // register map
  localparam logic [7:0] IDP_OFF_MAKER_CODE = 8'h00;
  localparam logic [7:0] IDP_OFF_PART_REV = 8'h01;
  localparam logic [7:0] IDP_READ_FILL = 8'h00;
  localparam logic [7:0] IDP_OFFSET_RESET = 8'h00;
  // arbitrary value, not a real maker code
  localparam logic [7:0] IDP_MAKER_CODE_DEF = 8'hA5;
  // ===========================================================
  // link constants
  localparam logic [6:0] IDP_SLAVE_ADDR_DEF = 7'h5E;
  localparam logic [2:0] IDP_LAST_BIT = 3'h7;
  localparam logic [2:0] IDP_BIT_ZERO = 3'h0;
  localparam logic IDP_DIR_READ = 1'h1;
  // ===========================================================
  // field layout of the part and revision register
  typedef struct packed {
    logic [1:0] silicon_revision;
    logic [1:0] variant_code;
    logic [3:0] part_code;
  } idp_part_rev_t;
  localparam idp_part_rev_t IDP_PART_REV_RESET = 8'h00;
  // ===========================================================
  // open-drain pin carrier
  typedef struct packed {
    logic level;
    logic oe;
  } idp_od_t;
  // ===========================================================
  // link state machine
  typedef enum logic [6:0] {
    IDP_ST_IDLE = 7'b0000001,
    IDP_ST_ADDR = 7'b0000010,
    IDP_ST_AACK = 7'b0000100,
    IDP_ST_WDATA = 7'b0001000,
    IDP_ST_WACK = 7'b0010000,
    IDP_ST_RDATA = 7'b0100000,
    IDP_ST_RACK = 7'b1000000
  } idp_state_t;
endpackage

// file: design/idp_i2c_slave_id_port.sv
// two-wire slave port serving the maker code and part/revision registers
//
// Behaviour
// - bus lines idle high; port only pulls low or releases, never drives high.
// - works as slave at 100 kbps, 400 kbps and 1 Mbps.
// - only 7-bit addresses decoded; no 10-bit, no general call.
// - responds to default slave address 0x5E.
// - data falling while clock high is a start; device detects it.
// - transmitter keeps data stable while clock high; changes only when low.
// - acknowledge low through ninth clock on address match and on each written byte.
// - direction 0 master writes; direction 1 device transmits.
// - bytes are eight data bits plus one acknowledge from the receiver.
// - data rising while clock high is a stop; link dropped.
// - port logic runs from oscillator enabled on bus access.
// - registers load defaults when supply passes lockout, before serving.
// - register read uses repeated start between offset write and read.
// - read-only maker code at offset 00h.
// - offset 01h: revision 7-6, variant 5-4, part 3-0, from OTP.
`timescale 1ns/1ps
module idp_i2c_slave_id_port #(
  parameter logic [6:0] SLAVE_ADDR = idp_pkg::IDP_SLAVE_ADDR_DEF,
  parameter logic [7:0] MAKER_CODE = idp_pkg::IDP_MAKER_CODE_DEF
) (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic osc_clk_i,
  input wire logic supply_ok_i,
  input wire idp_pkg::idp_part_rev_t otp_part_rev_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic scl_oe_o,
  output logic sda_o,
  output logic sda_oe_o,
  output logic osc_en_o,
  output logic regs_loaded_o
);
  import idp_pkg::*;

  if (SLAVE_ADDR[6:3] == 4'hF || SLAVE_ADDR == 7'h00) begin
    $error("slave address collides with reserved address space");
  end

  // ===========================================================
  // system domain: pin activity, supply, register load
  logic [1:0] sys_scl_sync;
  logic [1:0] sys_sda_sync;
  logic [1:0] sup_sync;
  logic [1:0] busy_sync;
  idp_part_rev_t part_rev;
  logic next_loaded;
  logic next_osc_en;
  idp_part_rev_t next_part_rev;
  logic link_busy;

  always_comb begin
    next_loaded = regs_loaded_o;
    next_part_rev = part_rev;
    if (sup_sync[1] && !regs_loaded_o) begin
      next_loaded = 1'b1;
      next_part_rev = otp_part_rev_i;
    end
    if (!sup_sync[1]) begin
      next_loaded = 1'b0;
    end
    next_osc_en = !sys_scl_sync[1] || !sys_sda_sync[1] || busy_sync[1];
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sys_scl_sync <= 2'h3;
      sys_sda_sync <= 2'h3;
      sup_sync <= 2'h0;
      busy_sync <= 2'h0;
      part_rev <= IDP_PART_REV_RESET;
      osc_en_o <= 1'b0;
      regs_loaded_o <= 1'b0;
    end else begin
      sys_scl_sync <= {sys_scl_sync[0], scl_i};
      sys_sda_sync <= {sys_sda_sync[0], sda_i};
      sup_sync <= {sup_sync[0], supply_ok_i};
      busy_sync <= {busy_sync[0], link_busy};
      part_rev <= next_part_rev;
      osc_en_o <= next_osc_en;
      regs_loaded_o <= next_loaded;
    end
  end

  // ===========================================================
  // link domain: reset release and synchronisers
  logic [1:0] lrst_sync;
  logic lrst_b;
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic [1:0] ready_sync;
  logic scl_d;
  logic sda_d;

  always_ff @(posedge osc_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lrst_sync <= 2'h0;
    end else begin
      lrst_sync <= {lrst_sync[0], 1'b1};
    end
  end
  assign lrst_b = lrst_sync[1];

  always_ff @(posedge osc_clk_i or negedge lrst_b) begin
    if (!lrst_b) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      ready_sync <= 2'h0;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], scl_i};
      sda_sync <= {sda_sync[0], sda_i};
      ready_sync <= {ready_sync[0], regs_loaded_o};
      scl_d <= scl_sync[1];
      sda_d <= sda_sync[1];
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  // only sample on clock edges; data moves while low
  assign scl_rise = scl_sync[1] && !scl_d;
  assign scl_fall = !scl_sync[1] && scl_d;
  assign start_seen = scl_sync[1] && scl_d && sda_d && !sda_sync[1];
  assign stop_seen = scl_sync[1] && scl_d && !sda_d && sda_sync[1];

  // ===========================================================
  // link domain: transfer state machine
  idp_state_t state;
  logic [2:0] bit_cnt;
  logic byte_full;
  logic [7:0] rx_byte;
  logic [7:0] tx_byte;
  logic dir_read;
  logic offset_next;
  logic [7:0] offset;
  logic nack;
  logic drive_low;
  logic [7:0] id_word;
  idp_state_t next_state;
  logic [2:0] next_bit_cnt;
  logic next_byte_full;
  logic [7:0] next_rx_byte;
  logic [7:0] next_tx_byte;
  logic next_dir_read;
  logic next_offset_next;
  logic [7:0] next_offset;
  logic next_nack;
  logic next_drive_low;
  logic [7:0] next_id_word;
  logic [7:0] read_word;

  function automatic logic [7:0] idp_read_mux(input logic [7:0] off, input logic [7:0] pr);
    logic [7:0] val;
    val = IDP_READ_FILL;
    if (off == IDP_OFF_MAKER_CODE) begin
      val = MAKER_CODE;
    end
    if (off == IDP_OFF_PART_REV) begin
      val = pr;
    end
    return val;
  endfunction

  assign read_word = idp_read_mux(offset, id_word);
  assign link_busy = (state != IDP_ST_IDLE);

  always_comb begin
    next_state = state;
    next_bit_cnt = bit_cnt;
    next_byte_full = byte_full;
    next_rx_byte = rx_byte;
    next_tx_byte = tx_byte;
    next_dir_read = dir_read;
    next_offset_next = offset_next;
    next_offset = offset;
    next_nack = nack;
    next_drive_low = drive_low;
    // part word is frozen before the ready level arrives
    next_id_word = ready_sync[1] ? part_rev : id_word;
    // eight data bits counted on rising clock
    if (scl_rise && (state == IDP_ST_ADDR || state == IDP_ST_WDATA ||
                     state == IDP_ST_RDATA)) begin
      next_rx_byte = {rx_byte[6:0], sda_sync[1]};
      next_bit_cnt = bit_cnt + 3'h1;
      next_byte_full = (bit_cnt == IDP_LAST_BIT);
    end
    if (scl_rise && state == IDP_ST_RACK) begin
      next_nack = sda_sync[1];
    end
    if (scl_fall) begin
      case (state)
        IDP_ST_ADDR: begin
          if (byte_full) begin
            next_byte_full = 1'b0;
            if (rx_byte[7:1] == SLAVE_ADDR && ready_sync[1]) begin
              next_state = IDP_ST_AACK;
              next_drive_low = 1'b1;
              next_dir_read = rx_byte[0];
              next_offset_next = 1'b1;
            end else begin
              next_state = IDP_ST_IDLE;
            end
          end
        end
        IDP_ST_AACK: begin
          next_bit_cnt = IDP_BIT_ZERO;
          if (dir_read == IDP_DIR_READ) begin
            next_state = IDP_ST_RDATA;
            next_drive_low = !read_word[7];
            next_tx_byte = {read_word[6:0], 1'b0};
          end else begin
            next_state = IDP_ST_WDATA;
            next_drive_low = 1'b0;
          end
        end
        IDP_ST_WDATA: begin
          if (byte_full) begin
            next_byte_full = 1'b0;
            next_state = IDP_ST_WACK;
            next_drive_low = 1'b1;
            // first byte is the offset; registers are read-only
            if (offset_next) begin
              next_offset = rx_byte;
              next_offset_next = 1'b0;
            end
          end
        end
        IDP_ST_WACK: begin
          next_state = IDP_ST_WDATA;
          next_drive_low = 1'b0;
        end
        IDP_ST_RDATA: begin
          if (byte_full) begin
            next_byte_full = 1'b0;
            next_state = IDP_ST_RACK;
            next_drive_low = 1'b0;
          end else begin
            next_drive_low = !tx_byte[7];
            next_tx_byte = {tx_byte[6:0], 1'b0};
          end
        end
        IDP_ST_RACK: begin
          next_bit_cnt = IDP_BIT_ZERO;
          if (nack) begin
            next_state = IDP_ST_IDLE;
          end else begin
            next_state = IDP_ST_RDATA;
            next_drive_low = !read_word[7];
            next_tx_byte = {read_word[6:0], 1'b0};
          end
        end
        default: next_state = state;
      endcase
    end
    if (start_seen) begin
      next_state = IDP_ST_ADDR;
      next_bit_cnt = IDP_BIT_ZERO;
      next_byte_full = 1'b0;
      next_drive_low = 1'b0;
    end
    if (stop_seen) begin
      next_state = IDP_ST_IDLE;
      next_drive_low = 1'b0;
    end
  end

  always_ff @(posedge osc_clk_i or negedge lrst_b) begin
    if (!lrst_b) begin
      state <= IDP_ST_IDLE;
      bit_cnt <= IDP_BIT_ZERO;
      byte_full <= 1'b0;
      rx_byte <= IDP_READ_FILL;
      tx_byte <= IDP_READ_FILL;
      dir_read <= 1'b0;
      offset_next <= 1'b0;
      offset <= IDP_OFFSET_RESET;
      nack <= 1'b1;
      drive_low <= 1'b0;
      id_word <= IDP_PART_REV_RESET;
    end else begin
      state <= next_state;
      bit_cnt <= next_bit_cnt;
      byte_full <= next_byte_full;
      rx_byte <= next_rx_byte;
      tx_byte <= next_tx_byte;
      dir_read <= next_dir_read;
      offset_next <= next_offset_next;
      offset <= next_offset;
      nack <= next_nack;
      drive_low <= next_drive_low;
      id_word <= next_id_word;
    end
  end

  // ===========================================================
  // open-drain pin outputs
  idp_od_t sda_pin;
  assign sda_pin = '{level: 1'b0, oe: drive_low};

  // pull low only; clock never stretched
  always_ff @(posedge osc_clk_i or negedge lrst_b) begin
    if (!lrst_b) begin
      sda_o <= 1'b0;
      sda_oe_o <= 1'b0;
      scl_o <= 1'b0;
      scl_oe_o <= 1'b0;
    end else begin
      sda_o <= sda_pin.level;
      sda_oe_o <= sda_pin.oe;
      scl_o <= 1'b0;
      scl_oe_o <= 1'b0;
    end
  end
endmodule

// file: verification/idp_i2c_slave_id_port_assertions.sv
// pin-level checks for the two-wire identification port
`timescale 1ns/1ps
module idp_id_port_checker (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic osc_clk_i,
  input wire logic supply_ok_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic scl_o,
  input wire logic scl_oe_o,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic osc_en_o,
  input wire logic regs_loaded_o
);
  // ==========
  // bus conditions on the wire
  sequence s_start;
    scl_i && $fell(sda_i);
  endsequence
  sequence s_stop;
    scl_i && $rose(sda_i);
  endsequence
  // ==========
  // link domain
  a_pins_pull_low: assert property (@(posedge osc_clk_i) disable iff (!rst_b_i)
    !scl_oe_o && !scl_o && !sda_o) else $error("port drives high or clock");
  a_stable_high: assert property (@(posedge osc_clk_i) disable iff (!rst_b_i)
    scl_i && $past(scl_i) |-> $stable(sda_oe_o)) else $error("data moved in clock high");
  a_ack_holds: assert property (@(posedge osc_clk_i) disable iff (!rst_b_i)
    $rose(scl_i) && sda_oe_o |=> sda_oe_o [*5]) else $error("pull dropped in clock high");
  a_start_quiet: assert property (@(posedge osc_clk_i) disable iff (!rst_b_i)
    s_start |=> !sda_oe_o [*8]) else $error("pull right after start");
  a_stop_releases: assert property (@(posedge osc_clk_i) disable iff (!rst_b_i)
    s_stop |=> !sda_oe_o [*8]) else $error("pull after stop");
  // ==========
  // system domain
  a_osc_wakes: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    !scl_i || !sda_i |-> ##[1:4] osc_en_o) else $error("oscillator not enabled");
  a_quiet_unloaded: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    !regs_loaded_o |-> !sda_oe_o) else $error("answer before load");
  a_loaded_rises: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    $rose(supply_ok_i) |-> ##[1:6] regs_loaded_o) else $error("load missing");
  a_loaded_drops: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    $fell(supply_ok_i) |-> ##[1:6] !regs_loaded_o) else $error("load kept");
endmodule
bind idp_i2c_slave_id_port idp_id_port_checker i_chk (.sys_clk_i, .rst_b_i, .osc_clk_i,
  .supply_ok_i, .scl_i, .sda_i, .scl_o, .scl_oe_o, .sda_o, .sda_oe_o, .osc_en_o, .regs_loaded_o);

// file: verification/idp_bus_master.sv
// bus master model for the two-wire port
`timescale 1ns/1ps
module idp_bus_master (
  input wire logic sys_clk_i,
  input wire logic sda_i,
  output logic scl_oe_o,
  output logic sda_oe_o
);
  // ==========
  // line control
  // released lines float high
  initial begin
    scl_oe_o <= 1'b0;
    sda_oe_o <= 1'b0;
  end
  // quarter-bit length in clocks; 25 gives 1 Mbps
  int q = 25;
  // set both pulls, hold n quarter bits
  task automatic ph(input logic c, input logic d, input int n);
    scl_oe_o <= c;
    sda_oe_o <= d;
    repeat (q * n) @(posedge sys_clk_i);
  endtask
  task automatic start();
    ph(1'b1, sda_oe_o, 1);
    ph(1'b1, 1'b0, 1);
    ph(1'b0, 1'b0, 2);
    ph(1'b0, 1'b1, 2);
  endtask
  task automatic stop();
    ph(1'b1, sda_oe_o, 1);
    ph(1'b1, 1'b1, 1);
    ph(1'b0, 1'b1, 2);
    ph(1'b0, 1'b0, 2);
  endtask
  task automatic bit_io(input logic b, output logic r);
    ph(1'b1, sda_oe_o, 1);
    ph(1'b1, !b, 1);
    ph(1'b0, !b, 2);
    r = sda_i;
  endtask
  task automatic byte_io(input logic [7:0] d, input logic a, output logic [7:0] v,
                         output logic r);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], b);
      v[i] = b;
    end
    bit_io(a, r);
  endtask
endmodule

// file: verification/idp_i2c_slave_id_port_tb.sv
// self-checking bench for the two-wire identification port
`timescale 1ns/1ps
module idp_i2c_slave_id_port_tb;
  import idp_pkg::*;
  // arbitrary, not a real maker code
  localparam logic [7:0] TB_MAKER = 8'h3C;
  localparam logic [6:0] SA = IDP_SLAVE_ADDR_DEF;
  logic sys_clk = 1'b0;
  logic osc_clk = 1'b0;
  logic rst_b = 1'b0;
  logic supply_ok = 1'b0;
  idp_part_rev_t otp = 8'h96;
  logic scl_o, scl_oe, sda_o, sda_oe, osc_en, loaded, m_scl, m_sda, scl_w, sda_w;
  int bad_count = 0;
  int checks_done = 0;
  assign scl_w = !(scl_oe | m_scl);
  assign sda_w = !(sda_oe | m_sda);
  always #5 sys_clk = !sys_clk;
  always #32 osc_clk = !osc_clk;
  idp_i2c_slave_id_port #(.MAKER_CODE(TB_MAKER)) i_dut (.sys_clk_i(sys_clk), .rst_b_i(rst_b),
    .osc_clk_i(osc_clk), .supply_ok_i(supply_ok), .otp_part_rev_i(otp), .scl_i(scl_w),
    .sda_i(sda_w), .scl_o(scl_o), .scl_oe_o(scl_oe), .sda_o(sda_o), .sda_oe_o(sda_oe),
    .osc_en_o(osc_en), .regs_loaded_o(loaded));
  idp_bus_master i_m (.sys_clk_i(sys_clk), .sda_i(sda_w), .scl_oe_o(m_scl), .sda_oe_o(m_sda));
  // ==========
  // helpers
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    checks_done++;
    if (s !== e) begin
      bad_count++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic hdr(input logic [6:0] a, input logic rw, input logic e);
    logic [7:0] v;
    logic r;
    i_m.start();
    i_m.byte_io({a, rw}, 1'b1, v, r);
    chk("addr_ack", {7'h0, e}, {7'h0, !r}); // address answer
  endtask
  task automatic rd(input logic [7:0] off, input logic [7:0] e, input int n);
    logic [7:0] v;
    logic r;
    hdr(SA, 1'b0, 1'b1);
    i_m.byte_io(off, 1'b1, v, r);
    chk("off_ack", 8'h00, {7'h0, r}); // offset acked
    hdr(SA, IDP_DIR_READ, 1'b1); // read turn
    for (int i = 1; i <= n; i++) begin
      i_m.byte_io(8'hFF, i == n, v, r);
      chk("rd_data", e, v); // register data
    end
    i_m.stop();
  endtask
  task automatic t_power(input logic on, input idp_part_rev_t w);
    otp <= w;
    @(posedge sys_clk);
    supply_ok <= on;
    for (int i = 0; i < 20 && loaded !== on; i++) @(posedge sys_clk);
    chk("loaded", {7'h0, on}, {7'h0, loaded}); // load flag
    if (loaded !== on) begin
      results();
    end else begin
      repeat (100) @(posedge sys_clk);
    end
  endtask
  // ==========
  // scenarios
  task automatic t_unloaded();
    logic [7:0] v;
    logic r;
    chk("osc_idle", 8'h00, {7'h0, osc_en}); // idle bus, oscillator off
    i_m.start();
    chk("osc_wake", 8'h01, {7'h0, osc_en}); // access wakes oscillator
    i_m.byte_io({SA, 1'b0}, 1'b1, v, r);
    chk("addr_ack", 8'h01, {7'h0, r}); // silent before load
    i_m.stop();
    $display("test unloaded done");
  endtask
  task automatic t_addr();
    logic [6:0] bad_addr [4] = '{7'h00, 7'h5F, 7'h78, 7'h2F};
    foreach (bad_addr[i]) begin
      hdr(bad_addr[i], i[0], 1'b0); // foreign address
      i_m.stop();
    end
    $display("test addr done");
  endtask
  task automatic t_regs();
    rd(IDP_OFF_MAKER_CODE, TB_MAKER, 2); // maker code
    rd(IDP_OFF_PART_REV, 8'h96, 2); // part word
    rd(8'h02, IDP_READ_FILL, 1); // unmapped offset
    $display("test regs done");
  endtask
  task automatic t_rates();
    i_m.q = 250;
    hdr(SA, 1'b0, 1'b1); // address at 100 kbps
    i_m.stop();
    i_m.q = 63;
    rd(IDP_OFF_PART_REV, 8'h96, 1); // read near 400 kbps
    i_m.q = 25;
    $display("test rates done");
  endtask
  task automatic t_write();
    logic [7:0] v;
    logic r;
    hdr(SA, 1'b0, 1'b1);
    i_m.stop(); // link dropped
    hdr(SA, 1'b0, 1'b1);
    i_m.byte_io(IDP_OFF_MAKER_CODE, 1'b1, v, r);
    i_m.byte_io(8'h5A, 1'b1, v, r);
    chk("wr_ack", 8'h00, {7'h0, r}); // data acked
    i_m.stop();
    rd(IDP_OFF_MAKER_CODE, TB_MAKER, 1); // stays read-only
    $display("test write done");
  endtask
  task automatic t_reload();
    t_power(1'b0, 8'h41);
    t_unloaded();
    t_power(1'b1, 8'h41);
    rd(IDP_OFF_PART_REV, 8'h41, 1); // new word captured
    $display("test reload done");
  endtask
  initial begin
    repeat (8) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (20) @(posedge sys_clk);
    t_unloaded();
    t_power(1'b1, 8'h96);
    t_addr();
    t_regs();
    t_rates();
    t_write();
    t_reload();
    results();
  end
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
endmodule
